// >>> inc/lwm_regs.vh
// constants for the load-weigher menu and supervision block
// assumes one 20 MHz clock and a plain register port with 16-bit data
`ifndef LWM_REGS_VH
`define LWM_REGS_VH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LWM_CLK_HZ        20000000
`define LWM_TICK_MS       1
`define LWM_TICK_CYC      (`LWM_CLK_HZ / 1000 * `LWM_TICK_MS)
`define LWM_BOOT_SAVE_MIN 3
`define LWM_BOOT_SAVE_MS  (`LWM_BOOT_SAVE_MIN * 60 * 1000)
`define LWM_IDLE_SAVE_HR  1
`define LWM_IDLE_SAVE_MS  (`LWM_IDLE_SAVE_HR * 3600 * 1000)
`define LWM_LOCK_HOLD_S   3
`define LWM_LOCK_HOLD_MS  (`LWM_LOCK_HOLD_S * 1000)
`define LWM_MS_PER_S      10'h3E8
`define LWM_ZERO_CD_S     4'h5
// ----------------------------------------------------------------
// parameters and limits
// ----------------------------------------------------------------
`define LWM_P_ZERO        3'h0
`define LWM_P_SPAN        3'h1
`define LWM_P_CELL        3'h2
`define LWM_P_CHAIN       3'h3
`define LWM_P_CAP         3'h4
`define LWM_P_OVL         3'h5
`define LWM_P_AUX         3'h6
`define LWM_P_LOCK        3'h7
`define LWM_CHAIN_MAX_KG  16'h0032
`define LWM_LOCK_RESET    16'h0000
`define LWM_PRM_RESET     16'h0000
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define LWM_OFS_PRM       6'h00
`define LWM_OFS_CHK       6'h20
`define LWM_OFS_STAT      6'h24
// ----------------------------------------------------------------
// status fields and fault codes
// ----------------------------------------------------------------
`define LWM_ST_ERR_LSB    0
`define LWM_ST_STATE_LSB  4
`define LWM_ST_LOCK_BIT   7
`define LWM_ST_LOST_BIT   8
`define LWM_ST_RLY_LSB    9
`define LWM_ERR_NONE      4'h0
`define LWM_ERR_OPEN      4'h1
`define LWM_ERR_NEG       4'h2
`define LWM_ERR_POS       4'h3
`define LWM_ERR_POL       4'h4
`define LWM_ERR_SHORT     4'h5
`define LWM_ERR_LOST      4'h6
`define LWM_ERR_SENS      4'h7
`endif

// >>> verilog/lwm_menu_ctrl.v
// three-key menu, lock, energy saving, relays and fault codes of a load weigher
// assumes keys and sensor flags synchronous to clk, raw load already in kg
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`include "lwm_regs.vh"

module lwm_menu_ctrl #(
    parameter        TICK_CYC     = `LWM_TICK_CYC,
    parameter [21:0] BOOT_SAVE_MS = `LWM_BOOT_SAVE_MS,
    parameter [21:0] IDLE_SAVE_MS = `LWM_IDLE_SAVE_MS,
    parameter [21:0] LOCK_HOLD_MS = `LWM_LOCK_HOLD_MS
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        key_menu,
    input  wire        key_select,
    input  wire        key_change,
    input  wire        hold_in,
    input  wire [15:0] load_raw,
    input  wire        sense_open,
    input  wire        sense_neg_ovf,
    input  wire        sense_pos_ovf,
    input  wire        sense_polarity,
    input  wire        display_short,
    input  wire        sense_low,
    input  wire [5:0]  bus_addr,
    input  wire [15:0] bus_wdata,
    input  wire        bus_wr,
    input  wire        bus_rd,
    output reg  [15:0] bus_rdata,
    output wire        capacity_relay,
    output wire        overload_relay,
    output wire        auxiliary_relay,
    output wire [2:0]  disp_state,
    output wire [2:0]  disp_index,
    output reg  [15:0] disp_value,
    output wire [1:0]  disp_digit,
    output wire        disp_blink,
    output reg  [3:0]  err_code,
    output wire        lock_armed
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [2:0] ST_RUN    = 3'h0;
    localparam [2:0] ST_SAVE   = 3'h1;
    localparam [2:0] ST_BROWSE = 3'h2;
    localparam [2:0] ST_EDIT   = 3'h3;
    localparam [2:0] ST_COMMIT = 3'h4;
    localparam [2:0] ST_LOCKP  = 3'h5;
    localparam [2:0] ST_ZERO   = 3'h6;

    reg  [15:0] prm_r [0:7];
    reg  [2:0]  state_r;
    reg  [2:0]  idx_r;
    reg  [1:0]  dig_r;
    reg  [15:0] edit_r;
    reg         lock_r;
    reg         programmed_r;
    reg         lost_r;
    reg  [21:0] idle_ms_r;
    reg  [21:0] hold_ms_r;
    reg  [9:0]  cd_ms_r;
    reg  [3:0]  cd_s_r;
    reg  [15:0] net_r;
    reg  [2:0]  relay_r;
    reg  [14:0] tick_cnt_r;
    reg         tick_r;
    reg         menu_q_r;
    reg         sel_q_r;
    reg         chg_q_r;
    reg  [15:0] chk_sum;
    reg  [15:0] rd_nxt;
    integer     i;
    integer     j;

    wire        menu_p   = key_menu & ~menu_q_r;
    wire        sel_p    = key_select & ~sel_q_r;
    wire        chg_p    = key_change & ~chg_q_r;
    wire        any_p    = menu_p | sel_p | chg_p;
    wire [21:0] idle_lim = programmed_r ? IDLE_SAVE_MS : BOOT_SAVE_MS;
    wire        idle_hit = (idle_ms_r >= idle_lim);
    wire        hold_hit = key_menu & tick_r & (hold_ms_r == LOCK_HOLD_MS - 22'h00_0001);
    wire [15:0] edit_bin;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function [15:0] bcd2bin;
        input [15:0] b;
        begin
            bcd2bin = b[15:12] * 16'd1000 + b[11:8] * 16'd100
                    + b[7:4] * 16'd10 + {12'h000, b[3:0]};
        end
    endfunction

    // change key rolls the highlighted digit 0..9 and leaves the rest alone
    function [15:0] inc_digit;
        input [15:0] v;
        input [1:0]  d;
        reg   [3:0]  n;
        begin
            n = v[d*4 +: 4];
            inc_digit = v;
            inc_digit[d*4 +: 4] = (n >= 4'h9) ? 4'h0 : n + 4'h1;
        end
    endfunction

    assign edit_bin = bcd2bin(edit_r);

    // ----------------------------------------------------------------
    // prescaled millisecond tick and key edges
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_cnt_r <= 15'h0000;
            tick_r     <= 1'b0;
            menu_q_r   <= 1'b0;
            sel_q_r    <= 1'b0;
            chg_q_r    <= 1'b0;
        end
        else
        begin
            tick_r   <= (tick_cnt_r == TICK_CYC - 1);
            menu_q_r <= key_menu;
            sel_q_r  <= key_select;
            chg_q_r  <= key_change;
            if (tick_cnt_r == TICK_CYC - 1)
                tick_cnt_r <= 15'h0000;
            else
                tick_cnt_r <= tick_cnt_r + 15'h0001;
        end
    end

    // ----------------------------------------------------------------
    // checksum over the stored parameters
    // ----------------------------------------------------------------
    always @*
    begin
        chk_sum = 16'h0000;
        for (j = 0; j < 8; j = j + 1)
            chk_sum = chk_sum + prm_r[j];
    end

    // ----------------------------------------------------------------
    // menu state machine, parameter store and register writes
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (i = 0; i < 7; i = i + 1)
                prm_r[i] <= `LWM_PRM_RESET;
            prm_r[7]     <= `LWM_LOCK_RESET;
            state_r      <= ST_RUN;
            idx_r        <= `LWM_P_ZERO;
            dig_r        <= 2'h0;
            edit_r       <= 16'h0000;
            lock_r       <= 1'b0;
            programmed_r <= 1'b0;
            lost_r       <= 1'b0;
            idle_ms_r    <= 22'h00_0000;
            hold_ms_r    <= 22'h00_0000;
            cd_ms_r      <= 10'h000;
            cd_s_r       <= 4'h0;
        end
        else
        begin
            // idle time restarts on any press, saturates at the limit in force (BOOT_SAVE_MS until programmed)
            if (any_p)
                idle_ms_r <= 22'h00_0000;
            else if (tick_r && !idle_hit)
                idle_ms_r <= idle_ms_r + 22'h00_0001;
            if (!key_menu)
                hold_ms_r <= 22'h00_0000;
            else if (tick_r && hold_ms_r != LOCK_HOLD_MS)
                hold_ms_r <= hold_ms_r + 22'h00_0001;

            case (state_r)
                ST_RUN:
                begin
                    if (menu_p && lock_r)
                    begin
                        state_r <= ST_LOCKP;
                        edit_r  <= 16'h0000;
                        dig_r   <= 2'h3;
                    end
                    else if (menu_p)
                    begin
                        state_r <= ST_BROWSE;
                        idx_r   <= `LWM_P_ZERO;
                    end
                end
                ST_SAVE:
                begin
                    if (menu_p)
                        state_r <= ST_RUN;
                end
                ST_BROWSE:
                begin
                    if (menu_p)
                    begin
                        if (idx_r == `LWM_P_LOCK)
                            state_r <= ST_RUN;
                        else
                            idx_r <= idx_r + 3'h1;
                    end
                    else if (sel_p)
                    begin
                        state_r <= ST_EDIT;
                        edit_r  <= prm_r[idx_r];
                        dig_r   <= 2'h3;
                    end
                end
                ST_EDIT, ST_LOCKP:
                begin
                    if (sel_p)
                        dig_r <= dig_r - 2'h1;
                    else if (chg_p)
                        edit_r <= inc_digit(edit_r, dig_r);
                    else if (menu_p && state_r == ST_LOCKP)
                    begin
                        if (edit_r == prm_r[`LWM_P_LOCK])
                        begin
                            lock_r  <= 1'b0;
                            state_r <= ST_BROWSE;
                            idx_r   <= `LWM_P_ZERO;
                        end
                        else
                            state_r <= ST_RUN;
                    end
                    else if (menu_p && idx_r == `LWM_P_ZERO)
                    begin
                        state_r <= ST_ZERO;
                        cd_ms_r <= 10'h000;
                        cd_s_r  <= `LWM_ZERO_CD_S;
                    end
                    else if (menu_p)
                        state_r <= ST_COMMIT;
                end
                ST_COMMIT:
                begin
                    if (menu_p)
                    begin
                        if (idx_r == `LWM_P_CHAIN && edit_bin > `LWM_CHAIN_MAX_KG)
                            state_r <= ST_BROWSE;
                        else
                        begin
                            prm_r[idx_r] <= edit_r;
                            programmed_r <= 1'b1;
                            lost_r       <= 1'b0;
                            if (idx_r == `LWM_P_LOCK)
                                state_r <= ST_RUN;
                            else
                            begin
                                state_r <= ST_BROWSE;
                                idx_r   <= idx_r + 3'h1;
                            end
                        end
                    end
                    else if (sel_p || chg_p)
                        state_r <= ST_BROWSE;
                end
                ST_ZERO:
                begin
                    if (tick_r && cd_ms_r == `LWM_MS_PER_S - 10'h001)
                    begin
                        cd_ms_r <= 10'h000;
                        cd_s_r  <= cd_s_r - 4'h1;
                        if (cd_s_r == 4'h1)
                        begin
                            prm_r[`LWM_P_ZERO] <= load_raw;
                            programmed_r       <= 1'b1;
                            lost_r             <= 1'b0;
                            state_r            <= ST_BROWSE;
                            idx_r              <= `LWM_P_SPAN;
                        end
                    end
                    else if (tick_r)
                        cd_ms_r <= cd_ms_r + 10'h001;
                end
                default:
                    state_r <= ST_RUN;
            endcase

            // long menu hold or idle timeout blanks the display and arms the lock
            if (state_r != ST_SAVE && (hold_hit || idle_hit))
            begin
                state_r <= ST_SAVE;
                lock_r  <= 1'b1;
            end

            // a register write lands after the key path, so software wins a tie
            if (bus_wr && bus_addr[5] == 1'b0)
                prm_r[bus_addr[4:2]] <= bus_wdata;
            // mismatch set wins over a same-cycle commit clear
            if (bus_wr && bus_addr == `LWM_OFS_CHK && bus_wdata != chk_sum)
                lost_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // weighing, relays and display
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            net_r <= 16'h0000;
        else if (!hold_in)
            net_r <= (load_raw > prm_r[`LWM_P_ZERO]) ?
                     load_raw - prm_r[`LWM_P_ZERO] : 16'h0000;
    end

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_relay
            always @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    relay_r[g] <= 1'b0;
                else
                    relay_r[g] <= (net_r >= bcd2bin(prm_r[`LWM_P_CAP + g]));
            end
        end
    endgenerate

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            disp_value <= 16'h0000;
            err_code   <= `LWM_ERR_NONE;
        end
        else
        begin
            case (state_r)
                ST_RUN:                      disp_value <= net_r;
                ST_BROWSE:                   disp_value <= prm_r[idx_r];
                ST_EDIT, ST_COMMIT, ST_LOCKP: disp_value <= edit_r;
                ST_ZERO:                     disp_value <= {12'h000, cd_s_r};
                default:                     disp_value <= 16'h0000;
            endcase
            // wiring faults outrank memory and calibration faults
            if (sense_open)
                err_code <= `LWM_ERR_OPEN;
            else if (sense_neg_ovf)
                err_code <= `LWM_ERR_NEG;
            else if (sense_pos_ovf)
                err_code <= `LWM_ERR_POS;
            else if (sense_polarity)
                err_code <= `LWM_ERR_POL;
            else if (display_short)
                err_code <= `LWM_ERR_SHORT;
            else if (lost_r)
                err_code <= `LWM_ERR_LOST;
            else if (sense_low)
                err_code <= `LWM_ERR_SENS;
            else
                err_code <= `LWM_ERR_NONE;
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    always @*
    begin
        rd_nxt = 16'h0000;
        if (bus_addr[5] == 1'b0 && bus_addr[1:0] == 2'h0)
            rd_nxt = prm_r[bus_addr[4:2]];
        else if (bus_addr == `LWM_OFS_CHK)
            rd_nxt = chk_sum;
        else if (bus_addr == `LWM_OFS_STAT)
        begin
            rd_nxt[`LWM_ST_ERR_LSB +: 4]   = err_code;
            rd_nxt[`LWM_ST_STATE_LSB +: 3] = state_r;
            rd_nxt[`LWM_ST_LOCK_BIT]       = lock_r;
            rd_nxt[`LWM_ST_LOST_BIT]       = lost_r;
            rd_nxt[`LWM_ST_RLY_LSB +: 3]   = relay_r;
        end
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            bus_rdata <= 16'h0000;
        else
            bus_rdata <= bus_rd ? rd_nxt : 16'h0000;
    end

    assign capacity_relay  = relay_r[0];
    assign overload_relay  = relay_r[1];
    assign auxiliary_relay = relay_r[2];
    assign disp_state      = state_r;
    assign disp_index      = idx_r;
    assign disp_digit      = dig_r;
    assign disp_blink      = hold_in | (state_r == ST_EDIT) | (state_r == ST_LOCKP);
    assign lock_armed      = lock_r;

endmodule // lwm_menu_ctrl

// >>> dv/lwm_menu_ctrl_props.sv
// concurrent checks on the ports of the load-weigher menu block
// assumes one clock domain and the active-low asynchronous reset rst_b
module lwm_menu_ctrl_chk (
    input wire       clk,
    input wire       rst_b,
    input wire       key_menu,
    input wire       key_select,
    input wire       hold_in,
    input wire       sense_open,
    input wire       sense_neg_ovf,
    input wire       sense_pos_ovf,
    input wire       sense_polarity,
    input wire [2:0] disp_state,
    input wire [2:0] disp_index,
    input wire [1:0] disp_digit,
    input wire       disp_blink,
    input wire [3:0] err_code,
    input wire       lock_armed
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    chk_save_exit: assert property (
        disp_state == 3'h1 && $rose(key_menu) |=> disp_state == 3'h0)
        else $error("energy save kept after menu press");
    chk_save_lock: assert property (
        $rose(disp_state == 3'h1) |-> ##[0:1] lock_armed)
        else $error("energy save without armed lock");
    chk_lock_prompt: assert property (
        disp_state == 3'h0 && lock_armed && $rose(key_menu) |=> disp_state == 3'h5)
        else $error("armed lock did not prompt");
    chk_code_exit: assert property (
        disp_state == 3'h4 && disp_index == 3'h7 && $rose(key_menu) |=> disp_state == 3'h0)
        else $error("saved code did not return to weight");
    chk_digit_step: assert property (
        disp_state == 3'h3 && $rose(key_select) |=> disp_digit == $past(disp_digit) - 2'h1)
        else $error("select did not move digit");
    chk_commit_next: assert property (
        disp_state == 3'h4 && $rose(key_menu) && disp_index inside {3'h2, 3'h4, 3'h5, 3'h6}
        |=> disp_state == 3'h2 && disp_index == $past(disp_index) + 3'h1)
        else $error("commit did not advance");
    chk_browse_step: assert property (
        disp_state == 3'h2 && $rose(key_menu) && !key_select && disp_index != 3'h7
        |=> disp_state == 3'h2 && disp_index == $past(disp_index) + 3'h1)
        else $error("menu did not step parameter");
    chk_err_open: assert property (
        sense_open |=> err_code == 4'h1)
        else $error("open sensor code missing");
    chk_err_pol: assert property (
        sense_polarity && !sense_open && !sense_neg_ovf && !sense_pos_ovf |=> err_code == 4'h4)
        else $error("polarity code missing");
    chk_hold_blink: assert property (
        hold_in |-> disp_blink)
        else $error("hold without blink");
    cover property (disp_state == 3'h5);
    cover property (disp_state == 3'h1 && lock_armed);
    cover property (err_code == 4'h6);
endmodule // lwm_menu_ctrl_chk

bind lwm_menu_ctrl lwm_menu_ctrl_chk i_lwm_menu_ctrl_chk (
    .clk(clk), .rst_b(rst_b), .key_menu(key_menu), .key_select(key_select),
    .hold_in(hold_in), .sense_open(sense_open), .sense_neg_ovf(sense_neg_ovf),
    .sense_pos_ovf(sense_pos_ovf), .sense_polarity(sense_polarity),
    .disp_state(disp_state), .disp_index(disp_index), .disp_digit(disp_digit),
    .disp_blink(disp_blink), .err_code(err_code), .lock_armed(lock_armed));

// >>> dv/lwm_pad.sv
// operator keypad model: menu, select and change keys
// assumes the block edge-detects keys, so each press is released one cycle
module lwm_pad (
    input wire   clk,
    output logic key_menu,
    output logic key_select,
    output logic key_change
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // key actions
    // ----------------------------------------------------------------
    initial {key_menu, key_select, key_change} = 3'b000;
    task automatic press(input int k);
        @(posedge clk);
        case (k)
            0: key_menu <= 1'b1;
            1: key_select <= 1'b1;
            default: key_change <= 1'b1;
        endcase
        @(posedge clk);
        {key_menu, key_select, key_change} <= 3'b000;
    endtask
    // long hold; no release pulse in between, so only one press edge is seen
    task automatic hold_menu(input int n);
        @(posedge clk);
        key_menu <= 1'b1;
        repeat (n) @(posedge clk);
        key_menu <= 1'b0;
    endtask
    // digit entry by increments, thousands digit first, with a select press between digits
    task automatic entry(input logic [15:0] v, input logic sel);
        if (sel)
            press(1);
        for (int d = 3; d >= 0; d--)
        begin
            repeat (v[4*d +: 4]) press(2);
            if (d > 0)
                press(1);
        end
    endtask
endmodule // lwm_pad

// >>> dv/tb_top.sv
// self-checking bench for the load-weigher menu block
// assumes the keypad model drives keys; the bench drives bus, load, hold and faults
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        hold_in = 1'b0;
    logic [15:0] load_raw = 16'h0000;
    logic [5:0]  flt = 6'h00;
    logic [5:0]  bus_addr = 6'h00;
    logic [15:0] bus_wdata = 16'h0000;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic        rd_seen = 1'b0;
    logic        key_menu, key_select, key_change, cap_rly, disp_blink, lock_armed;
    logic        ovl_rly, aux_rly;
    logic [15:0] bus_rdata, disp_value;
    logic [2:0]  disp_state, disp_index;
    logic [1:0]  disp_digit;
    logic [3:0]  err_code;
    logic [15:0] rd_q[$];
    int          fails = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          c0, ld, seed;

    always #25 clk = ~clk;

    // short counts keep the timeouts within a few thousand cycles
    lwm_menu_ctrl #(.TICK_CYC(10), .BOOT_SAVE_MS(22'h32), .IDLE_SAVE_MS(22'h50),
                    .LOCK_HOLD_MS(22'h5)) i_lwm_menu_ctrl (
        .clk(clk), .rst_b(rst_b), .key_menu(key_menu), .key_select(key_select),
        .key_change(key_change), .hold_in(hold_in), .load_raw(load_raw),
        .sense_open(flt[0]), .sense_neg_ovf(flt[1]), .sense_pos_ovf(flt[2]),
        .sense_polarity(flt[3]), .display_short(flt[4]), .sense_low(flt[5]),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .capacity_relay(cap_rly), .overload_relay(ovl_rly),
        .auxiliary_relay(aux_rly), .disp_state(disp_state), .disp_index(disp_index),
        .disp_value(disp_value), .disp_digit(disp_digit), .disp_blink(disp_blink),
        .err_code(err_code), .lock_armed(lock_armed));
    lwm_pad i_lwm_pad (.clk(clk), .key_menu(key_menu), .key_select(key_select),
                       .key_change(key_change));
    // ----------------------------------------------------------------
    // tasks and read monitor
    // ----------------------------------------------------------------
    task automatic print_verdict;
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(negedge clk);
    endtask
    task automatic key(input int k, input int n);
        repeat (n) i_lwm_pad.press(k);
        @(negedge clk);
    endtask
    task automatic wait_st(input logic [2:0] s, input int lim);
        int n;
        n = 0;
        while (disp_state !== s && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        chk(disp_state, s);
    endtask
    task automatic set_load(input logic [15:0] v, input logic h);
        @(posedge clk);
        load_raw <= v;
        hold_in <= h;
        repeat (3) @(negedge clk);
    endtask
    // read data stand only in the cycle after the strobe, so compare exactly there
    always @(negedge clk)
    begin
        if (rd_seen)
            chk(bus_rdata, rd_q.pop_front());
    end
    always @(posedge clk)
    begin
        rd_seen <= bus_rd;
        cyc++;
        if (cyc == 60000)
        begin
            fails++;
            print_verdict();
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        seed = $urandom(32'h0000_69b8);
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk({disp_state, lock_armed}, 16'h0000);
        wr(6'h10, 16'h0100);
        wr(6'h14, 16'h0200);
        rd(6'h10, 16'h0100);
        rd(6'h1c, 16'h0000);
        rd(6'h30, 16'h0000);
        for (int i = 0; i < 10; i++)
        begin
            ld = (i < 2) ? 99 + i : $urandom_range(300);
            set_load(ld[15:0], 1'b0);
            chk({ovl_rly, aux_rly, cap_rly}, {ld >= 200, 1'b1, ld >= 100});
        end
        set_load(16'h0000, 1'b0);
        set_load(16'h012c, 1'b1);
        chk({cap_rly, disp_blink}, 16'h0001);
        set_load(16'h012c, 1'b0);
        chk(cap_rly, 16'h0001);
        wait_st(3'h1, 700);
        chk(cyc >= 505, 16'h0001);
        chk(lock_armed, 16'h0001);
        key(0, 1);
        chk(disp_state, 16'h0000);
        key(0, 1);
        chk(disp_state, 16'h0005);
        key(0, 1);
        chk({disp_state, lock_armed}, 16'h0004);
        key(0, 2);
        chk(disp_index, 16'h0002);
        i_lwm_pad.entry(16'h0002, 1'b1);
        key(0, 2);
        chk(disp_index, 16'h0003);
        i_lwm_pad.entry(16'h0051, 1'b1);
        key(0, 2);
        chk({disp_state, disp_index}, 16'h0013);
        rd(6'h0c, 16'h0000);
        i_lwm_pad.entry(16'h0050, 1'b1);
        key(0, 2);
        rd(6'h0c, 16'h0050);
        i_lwm_pad.entry(16'h1000, 1'b1);
        key(0, 1);
        chk({disp_state, disp_index}, 16'h0024);
        key(0, 1);
        chk({disp_state, disp_index}, 16'h0015);
        i_lwm_pad.entry(16'h0001, 1'b1);
        key(0, 1);
        key(2, 1);
        chk({disp_state, disp_index}, 16'h0015);
        rd(6'h14, 16'h0200);
        rd(6'h10, 16'h1100);
        key(0, 2);
        i_lwm_pad.entry(16'h1234, 1'b1);
        key(0, 2);
        chk(disp_state, 16'h0000);
        rd(6'h1c, 16'h1234);
        i_lwm_pad.hold_menu(70);
        @(negedge clk);
        chk({disp_state, lock_armed}, 16'h0003);
        key(0, 3);
        chk(disp_state, 16'h0000);
        key(0, 1);
        chk({disp_state, disp_digit}, 16'h0017);
        i_lwm_pad.entry(16'h1234, 1'b0);
        key(0, 1);
        chk({disp_state, lock_armed}, 16'h0004);
        // select presses keep the idle timer from cutting the countdown short
        i_lwm_pad.press(1);
        key(0, 1);
        chk(disp_state, 16'h0006);
        @(negedge clk);
        chk(disp_value, 16'h0005);
        repeat (101)
        begin
            repeat (490) @(posedge clk);
            i_lwm_pad.press(1);
        end
        wait_st(3'h2, 1000);
        chk(disp_index, 16'h0001);
        rd(6'h00, 16'h012c);
        key(1, 1);
        c0 = cyc;
        wait_st(3'h1, 1200);
        chk(cyc - c0 >= 780, 16'h0001);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            flt <= 6'h01 << i;
            repeat (2) @(negedge clk);
            chk(err_code, (i == 5) ? 16'h0007 : 16'(i + 1));
        end
        @(posedge clk);
        flt <= 6'h00;
        wr(6'h20, 16'hffff);
        repeat (2) @(negedge clk);
        chk(err_code, 16'h0006);
        print_verdict();
    end
endmodule // tb_top
